// ===== verilog/cmbi_bus_unit.sv
`timescale 1ns/100ps

module cmbi_bus_unit (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Core side
  input  wire logic        core_req_valid_i,
  output logic             core_req_ready_o,
  input  wire logic        core_req_is_io_i,
  input  wire logic        core_req_write_i,
  input  wire logic [14:0] core_req_addr_i,
  input  wire logic [7:0]  core_req_wdata_i,
  input  wire logic        core_req_io_ext_i,
  input  wire logic        core_req_io_data_i,
  input  wire logic        core_instr_end_i,
  output logic             core_resp_valid_o,
  output logic [7:0]       core_rdata_o,
  output logic             core_int_enter_o,
  output logic [7:0]       core_int_vector_o,
  input  wire logic        core_status_wr_i,
  input  wire logic [7:0]  core_status_wdata_i,
  output logic [7:0]       core_status_o,
  output logic             slow_access_o,
  // Pins
  output logic [12:0]      low_address_lines_o,
  output logic             low_address_lines_oe_b_o,
  output logic             addr_bit13_or_extended_sel_o,
  output logic             addr_bit14_or_data_control_sel_o,
  input  wire logic        address_drive_enable_b_i,
  input  wire logic [7:0]  data_lines_i,
  output logic [7:0]       data_lines_o,
  output logic             data_lines_oe_b_o,
  input  wire logic        data_drive_enable_b_i,
  output logic             operation_request_o,
  input  wire logic        operation_acknowledge_i,
  output logic             memory_io_sel_o,
  output logic             read_write_o,
  output logic             write_strobe_o,
  input  wire logic        sense_i,
  output logic             flag_o,
  input  wire logic        interrupt_request_i,
  output logic             interrupt_acknowledge_o,
  input  wire logic        pause_i,
  output logic             run_wait_o
);

  // ---------------------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------------------
  // Upper address pins carry an address bit for memory, a qualifier for I/O.
  function automatic logic upper_pin(input logic is_io, input logic abit, input logic qual);
    upper_pin = is_io ? qual : abit;
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  cmbi_sync_if sync_bus ();

  assign sync_bus.raw = {data_lines_i, data_drive_enable_b_i, address_drive_enable_b_i,
                         sense_i, pause_i, interrupt_request_i, operation_acknowledge_i};

  cmbi_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .bus       (sync_bus.sync)
  );

  wire       ack_s     = sync_bus.synced[cmbi_pkg::SYNC_ACK];
  wire       interrupt_request_s  = sync_bus.synced[cmbi_pkg::SYNC_INTERRUPT_REQUEST];
  wire       pause_s   = sync_bus.synced[cmbi_pkg::SYNC_PAUSE];
  wire       sense_s   = sync_bus.synced[cmbi_pkg::SYNC_SENSE];
  wire       address_drive_enable_b_s = sync_bus.synced[cmbi_pkg::SYNC_ADDRESS_DRIVE_ENABLE_B];
  wire       dben_b_s  = sync_bus.synced[cmbi_pkg::SYNC_DBEN_B];
  wire [7:0] data_s    = sync_bus.synced[cmbi_pkg::SYNC_DATA +: cmbi_pkg::DATA_W];

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  cmbi_pkg::cmbi_state_t state;
  cmbi_pkg::cmbi_state_t next_state;

  logic [1:0]  phase;
  logic        at_boundary;
  logic [7:0]  status;
  logic [14:0] cur_addr;
  logic [7:0]  cur_wdata;
  logic        cur_is_io;
  logic        cur_write;
  logic        cur_ext;
  logic        cur_data;
  logic        cur_int;
  logic [3:0]  wait_cnt;
  logic        req_q;
  logic        strobe_q;
  logic        resp_q;
  logic        int_enter_q;
  logic        slow_q;
  logic [7:0]  rdata_q;
  logic [7:0]  vector_q;

  // ---------------------------------------------------------------------------
  // Sequencer decisions
  // ---------------------------------------------------------------------------
  // Processor cycles open only on the last phase of three.
  // three clock phases
  wire cycle_edge = (phase == cmbi_pkg::PHASE_LAST);

  wire inhibit = status[cmbi_pkg::STAT_INHIBIT];

  wire int_take = at_boundary && interrupt_request_s && !inhibit && !pause_s;

  wire pause_take = at_boundary && pause_s;

  wire idle_free = (state == cmbi_pkg::ST_IDLE) && cycle_edge;

  assign core_req_ready_o = idle_free && !int_take && !pause_take;

  wire core_start = core_req_ready_o && core_req_valid_i;
  wire int_start  = idle_free && int_take;

  wire ack_done = (state == cmbi_pkg::ST_REQ) && ack_s;

  // Next state selection.
  always_comb begin
    next_state = state;
    unique case (state)
      cmbi_pkg::ST_IDLE: begin
        if (idle_free && pause_take) begin
          next_state = cmbi_pkg::ST_PAUSE;
        end else if (int_start || core_start) begin
          next_state = cmbi_pkg::ST_SETUP;
        end
      end
      cmbi_pkg::ST_SETUP: begin
        next_state = cmbi_pkg::ST_REQ;
      end
      cmbi_pkg::ST_REQ: begin
        if (ack_s) begin
          next_state = cmbi_pkg::ST_RELEASE;
        end
      end
      cmbi_pkg::ST_RELEASE: begin
        if (!ack_s) begin
          next_state = cmbi_pkg::ST_IDLE;
        end
      end
      cmbi_pkg::ST_PAUSE: begin
        if (!pause_s) begin
          next_state = cmbi_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= cmbi_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // one clock drives the phase counter
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase <= cmbi_pkg::PHASE_FIRST;
    end else if (cycle_edge) begin
      phase <= cmbi_pkg::PHASE_FIRST;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Instruction boundary flag; a new end wins over the clear by a start.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      at_boundary <= 1'b1;
    end else if (core_instr_end_i) begin
      at_boundary <= 1'b1;
    end else if (core_start) begin
      at_boundary <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Upper status byte
  // ---------------------------------------------------------------------------
  // entry sets inhibit, and the set wins over a core write
  wire next_inhibit = (core_status_wr_i ? core_status_wdata_i[cmbi_pkg::STAT_INHIBIT] : inhibit)
                      | int_start;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status <= cmbi_pkg::STAT_RESET;
    end else begin
      if (core_status_wr_i) begin
        status <= core_status_wdata_i;
      end
      status[cmbi_pkg::STAT_INHIBIT] <= next_inhibit;
    end
  end

  // sense shows in the top status bit
  // sense read apart from the handshake
  assign core_status_o = {sense_s, status[cmbi_pkg::STAT_FLAG:0]};

  // flag driven straight from its latch
  assign flag_o = status[cmbi_pkg::STAT_FLAG];

  // ---------------------------------------------------------------------------
  // Captured operation
  // ---------------------------------------------------------------------------
  // operation fields held until the next operation starts
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_addr  <= 15'h0000;
      cur_wdata <= 8'h00;
      cur_is_io <= 1'b0;
      cur_write <= 1'b0;
      cur_ext   <= 1'b0;
      cur_data  <= 1'b0;
      cur_int   <= 1'b0;
    end else if (int_start) begin
      cur_addr  <= cmbi_pkg::VECTOR_ADDR;
      cur_wdata <= 8'h00;
      cur_is_io <= 1'b0;
      cur_write <= 1'b0;
      cur_ext   <= 1'b0;
      cur_data  <= 1'b0;
      cur_int   <= 1'b1;
    end else if (core_start) begin
      cur_addr  <= core_req_addr_i;
      cur_wdata <= core_req_wdata_i;
      cur_is_io <= core_req_is_io_i;
      cur_write <= core_req_write_i;
      cur_ext   <= core_req_io_ext_i;
      cur_data  <= core_req_io_data_i;
      cur_int   <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Handshake outputs
  // ---------------------------------------------------------------------------
  // Request rises a clock after address and type settle, drops on acknowledge.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_q    <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      req_q    <= (next_state == cmbi_pkg::ST_REQ);
      strobe_q <= (state == cmbi_pkg::ST_REQ) && (next_state == cmbi_pkg::ST_REQ) && cur_write;
    end
  end

  assign operation_request_o = req_q;
  assign write_strobe_o      = strobe_q;

  // acknowledge shown for the vector fetch
  assign interrupt_acknowledge_o = cur_int && (state != cmbi_pkg::ST_IDLE);

  assign memory_io_sel_o = !cur_is_io;

  assign read_write_o = cur_write;

  // ---------------------------------------------------------------------------
  // Address pins
  // ---------------------------------------------------------------------------
  // low address with external enable
  // device address sits in the low byte
  assign low_address_lines_o      = cur_addr[cmbi_pkg::LOW_ADDR_W-1:0];
  assign low_address_lines_oe_b_o = address_drive_enable_b_s;

  assign addr_bit13_or_extended_sel_o =
    upper_pin(cur_is_io, cur_addr[cmbi_pkg::ADDR_B13], cur_ext);

  assign addr_bit14_or_data_control_sel_o =
    upper_pin(cur_is_io, cur_addr[cmbi_pkg::ADDR_B14], cur_data);

  // ---------------------------------------------------------------------------
  // Data pins
  // ---------------------------------------------------------------------------
  // data drivers need a write and the enable
  wire drive_data = cur_write && (state == cmbi_pkg::ST_SETUP || state == cmbi_pkg::ST_REQ);

  assign data_lines_o      = cur_wdata;
  assign data_lines_oe_b_o = !(drive_data && !dben_b_s);

  // ---------------------------------------------------------------------------
  // Read data, vector capture and access timing
  // ---------------------------------------------------------------------------
  // acknowledge completes the transfer
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resp_q      <= 1'b0;
      int_enter_q <= 1'b0;
      rdata_q     <= 8'h00;
      vector_q    <= 8'h00;
    end else begin
      resp_q      <= ack_done && !cur_int;
      int_enter_q <= ack_done && cur_int;
      if (ack_done && !cur_int) begin
        rdata_q <= data_s;
      end
      // vector taken for a zero-relative call
      if (ack_done && cur_int) begin
        vector_q <= data_s;
      end
    end
  end

  assign core_resp_valid_o = resp_q;
  assign core_rdata_o      = rdata_q;
  assign core_int_enter_o  = int_enter_q;
  assign core_int_vector_o = vector_q;

  // mark accesses slower than the fast budget
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_cnt <= 4'h0;
      slow_q   <= 1'b0;
    end else begin
      if (state == cmbi_pkg::ST_IDLE) begin
        wait_cnt <= 4'h0;
      end else if (state == cmbi_pkg::ST_REQ && wait_cnt != cmbi_pkg::WAIT_CNT_MAX) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
      slow_q <= ack_done && (wait_cnt >= cmbi_pkg::FAST_ACCESS_CNT);
    end
  end

  assign slow_access_o = slow_q;

  // ---------------------------------------------------------------------------
  // Run/wait status
  // ---------------------------------------------------------------------------
  // waiting while paused
  assign run_wait_o = (state != cmbi_pkg::ST_PAUSE);

endmodule

// ===== verilog/cmbi_pkg.sv
package cmbi_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W     = 15;
  localparam int LOW_ADDR_W = 13;
  localparam int DATA_W     = 8;
  localparam int ADDR_B13   = 13;
  localparam int ADDR_B14   = 14;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  // One processor cycle spans three input clock periods.
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST  = 2'h2;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int FAST_ACCESS_NS = 800;
  // Longest time rounds down to whole cycles.
  localparam int FAST_ACCESS_CYC = FAST_ACCESS_NS / CLK_PERIOD_NS;
  localparam logic [3:0] FAST_ACCESS_CNT = 4'(FAST_ACCESS_CYC);
  localparam logic [3:0] WAIT_CNT_MAX    = 4'hF;

  // ---------------------------------------------------------------------------
  // Synchronised pin inputs, bit positions in the bundle
  // ---------------------------------------------------------------------------
  localparam int SYNC_W       = 14;
  localparam int SYNC_ACK     = 0;
  localparam int SYNC_INTERRUPT_REQUEST  = 1;
  localparam int SYNC_PAUSE   = 2;
  localparam int SYNC_SENSE   = 3;
  localparam int SYNC_ADDRESS_DRIVE_ENABLE_B = 4;
  localparam int SYNC_DBEN_B  = 5;
  localparam int SYNC_DATA    = 6;

  // ---------------------------------------------------------------------------
  // Upper status byte fields and reset value
  // ---------------------------------------------------------------------------
  localparam int STAT_INHIBIT = 5;
  localparam int STAT_FLAG    = 6;
  localparam int STAT_SENSE   = 7;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // Address used by the interrupt vector fetch.
  localparam logic [14:0] VECTOR_ADDR = 15'h0000;

  // ---------------------------------------------------------------------------
  // Bus sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_REQ,
    ST_RELEASE,
    ST_PAUSE
  } cmbi_state_t;

endpackage

// ===== verilog/cmbi_sync_if.sv
`timescale 1ns/100ps

// Raw pin levels in, two-stage synchronised levels out.
interface cmbi_sync_if;
  logic [cmbi_pkg::SYNC_W-1:0] raw;
  logic [cmbi_pkg::SYNC_W-1:0] synced;

  modport user (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// ===== verilog/cmbi_sync.sv
`timescale 1ns/100ps

module cmbi_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  cmbi_sync_if.sync bus
);

  // ---------------------------------------------------------------------------
  // Two flip-flop synchroniser per pin
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < cmbi_pkg::SYNC_W; g++) begin : g_bit
      logic meta;
      logic stable;

      // The first stage is read only by the second stage.
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta   <= bus.raw[g];
          stable <= meta;
        end
      end

      assign bus.synced[g] = stable;
    end
  endgenerate

endmodule

// ===== testbench/cmbi_bus_unit_chk.sv
`timescale 1ns/100ps

module cmbi_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        core_req_valid_i,
  input wire logic        core_req_ready_o,
  input wire logic        core_req_is_io_i,
  input wire logic [14:0] core_req_addr_i,
  input wire logic        core_req_io_ext_i,
  input wire logic        core_req_io_data_i,
  input wire logic        core_resp_valid_o,
  input wire logic [12:0] low_address_lines_o,
  input wire logic        low_address_lines_oe_b_o,
  input wire logic        addr_bit13_or_extended_sel_o,
  input wire logic        addr_bit14_or_data_control_sel_o,
  input wire logic        address_drive_enable_b_i,
  input wire logic        data_lines_oe_b_o,
  input wire logic        operation_request_o,
  input wire logic        operation_acknowledge_i,
  input wire logic        memory_io_sel_o,
  input wire logic        read_write_o,
  input wire logic        write_strobe_o,
  input wire logic        interrupt_acknowledge_o,
  input wire logic        run_wait_o
);
  logic [14:0] c_addr;
  logic        c_io;
  logic        c_ext;
  logic        c_dat;
  logic        xfer;

  // Keeps the fields of the request last taken by the unit.
  always_ff @(posedge ref_clk_i) begin
    if (core_req_valid_i && core_req_ready_o) begin
      c_addr <= core_req_addr_i;
      c_io   <= core_req_is_io_i;
      c_ext  <= core_req_io_ext_i;
      c_dat  <= core_req_io_data_i;
    end
  end

  // A normal transfer is under way on the pins.
  assign xfer = operation_request_o && !interrupt_acknowledge_o;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ---------------------------------------------------------------------------
  // Pin handshake
  // ---------------------------------------------------------------------------
  a_req_hold: assert property (
    operation_request_o && $past(operation_request_o) |->
      $stable({low_address_lines_o, read_write_o, memory_io_sel_o}))
    else $error("outputs moved under request");
  a_resp_ack: assert property (
    core_resp_valid_o |-> !operation_request_o && $past(operation_acknowledge_i, 3))
    else $error("response without acknowledge");
  a_strobe_wr: assert property (
    write_strobe_o |-> operation_request_o && read_write_o)
    else $error("strobe outside a write");
  a_ready_gap: assert property (
    core_req_ready_o |=> !core_req_ready_o [*2])
    else $error("cycle shorter than three clocks");

  // ---------------------------------------------------------------------------
  // Address and type outputs
  // ---------------------------------------------------------------------------
  a_low_addr: assert property (
    xfer |-> low_address_lines_o == c_addr[12:0])
    else $error("low address wrong");
  a_bit13_mux: assert property (
    xfer |-> addr_bit13_or_extended_sel_o == (c_io ? c_ext : c_addr[13]))
    else $error("bit 13 output wrong");
  a_bit14_mux: assert property (
    xfer |-> addr_bit14_or_data_control_sel_o == (c_io ? c_dat : c_addr[14]))
    else $error("bit 14 output wrong");
  a_mem_io: assert property (
    xfer |-> memory_io_sel_o == !c_io)
    else $error("memory or io indicator wrong");
  a_drive_dir: assert property (
    !data_lines_oe_b_o |-> read_write_o)
    else $error("data driven on a read");
  a_addr_oe: assert property (
    low_address_lines_oe_b_o == $past(address_drive_enable_b_i, 2))
    else $error("address enable not followed");
  a_interrupt_acknowledge_fetch: assert property (
    interrupt_acknowledge_o && operation_request_o |->
      memory_io_sel_o && !read_write_o && low_address_lines_o == 13'h0000)
    else $error("vector fetch malformed");
  a_pause_quiet: assert property (
    !run_wait_o |-> !core_req_ready_o && !operation_request_o)
    else $error("activity while waiting");

  // Main scenarios reached.
  c_write: cover property (write_strobe_o);
  c_int: cover property (interrupt_acknowledge_o && operation_request_o);
  c_wait: cover property (!run_wait_o);
endmodule

bind cmbi_bus_unit cmbi_chk i_cmbi_chk (.*);

// ===== testbench/cmbi_mem.sv
`timescale 1ns/100ps

module cmbi_mem (
  input  wire logic        ref_clk_i,
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic        strobe_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic [7:0]  rdata_i,
  output logic      [7:0]  dq_o,
  output logic             ack_o
);
  logic [3:0]  wait_cnt  = 4'h0;
  logic [7:0]  last_dq   = 8'h00;
  logic [7:0]  last_wdata = 8'h00;
  logic [12:0] last_addr = 13'h0000;

  initial ack_o = 1'b0;

  // delayed acknowledge. Held until the request is seen low.
  always @(posedge ref_clk_i) begin
    if (!req_i) begin
      wait_cnt <= 4'h0;
      ack_o    <= 1'b0;
    end else if (wait_cnt >= delay_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // Records the address and the strobed write data.
  always @(posedge ref_clk_i) begin
    last_dq <= dq_o;
    if (req_i) begin
      last_addr <= addr_i;
    end
    if (strobe_i) begin
      last_wdata <= wdata_i;
    end
  end

  // read data. Released lines show a pattern that changes every cycle.
  assign dq_o = ((req_i || ack_o) && !wr_i) ? rdata_i : ~last_dq;
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps

module tb;
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i, core_req_valid_i, core_req_is_io_i, core_req_write_i, core_req_io_ext_i;
  logic        core_req_io_data_i, core_instr_end_i, core_status_wr_i, address_drive_enable_b_i;
  logic        data_drive_enable_b_i, operation_acknowledge_i, sense_i, interrupt_request_i, pause_i;
  logic        core_req_ready_o, core_resp_valid_o, core_int_enter_o, slow_access_o, flag_o;
  logic        low_address_lines_oe_b_o, addr_bit13_or_extended_sel_o, addr_bit14_or_data_control_sel_o;
  logic        data_lines_oe_b_o, operation_request_o, memory_io_sel_o, read_write_o, write_strobe_o;
  logic        interrupt_acknowledge_o, run_wait_o, drv_seen, ack_seen;
  logic [14:0] core_req_addr_i;
  logic [12:0] low_address_lines_o;
  logic [7:0]  core_req_wdata_i, core_status_wdata_i, data_lines_i, data_lines_o, core_rdata_o;
  logic [7:0]  core_int_vector_o, core_status_o, mem_dq, rd_val;
  logic [3:0]  delay;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;

  cmbi_bus_unit i_cmbi_bus_unit (.*);

  cmbi_mem i_cmbi_mem (
    .ref_clk_i (ref_clk_i),
    .req_i     (operation_request_o),
    .wr_i      (read_write_o),
    .strobe_i  (write_strobe_o),
    .addr_i    (low_address_lines_o),
    .wdata_i   (data_lines_i),
    .delay_i   (delay),
    .rdata_i   (rd_val),
    .dq_o      (mem_dq),
    .ack_o     (operation_acknowledge_i)
  );

  // The data wire carries the unit's byte while it drives, else the memory's.
  assign data_lines_i = !data_lines_oe_b_o ? data_lines_o : mem_dq;

  // Clock, timeout and bus watchers.
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (!data_lines_oe_b_o) drv_seen <= 1'b1;
    if (interrupt_acknowledge_o) ack_seen <= 1'b1;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issues one operation and waits for its response.
  task automatic op(input logic io, wr, input logic [14:0] a, input logic [7:0] d, input logic ext, dat);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    {core_req_is_io_i, core_req_write_i, core_req_addr_i, core_req_wdata_i} = {io, wr, a, d};
    {core_req_io_ext_i, core_req_io_data_i, core_req_valid_i} = {ext, dat, 1'b1};
    while (core_req_ready_o !== 1'b1 && n < 60) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    core_req_valid_i = 1'b0;
    while (core_resp_valid_o !== 1'b1 && n < 120) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("response", 1, core_resp_valid_o);
  endtask

  task automatic pulse(ref logic s);
    @(negedge ref_clk_i);
    s = 1'b1;
    @(negedge ref_clk_i);
    s = 1'b0;
  endtask

  task automatic set_status(input logic [7:0] v);
    core_status_wdata_i = v;
    pulse(core_status_wr_i);
    @(negedge ref_clk_i);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk("request", 0, operation_request_o);
    chk("mem sel", 1, memory_io_sel_o);
    chk("run", 1, run_wait_o);
    chk("status", 0, core_status_o);
    chk("data oe", 1, data_lines_oe_b_o);
    $display("t_reset done");
  endtask

  task automatic t_mem();
    delay = 4'h1;
    op(0, 1, 15'h6ABC, 8'hA5, 0, 0);
    chk("wdata", 8'hA5, i_cmbi_mem.last_wdata);
    chk("waddr", 13'h0ABC, i_cmbi_mem.last_addr);
    chk("fast", 0, slow_access_o);
    {delay, rd_val} = {4'hC, 8'h3C};
    op(0, 0, 15'h1234, 8'h00, 0, 0);
    chk("rdata", 8'h3C, core_rdata_o);
    chk("slow", 1, slow_access_o);
    $display("t_mem done");
  endtask

  task automatic t_io();
    delay = 4'h0;
    for (int i = 0; i < 4; i++) begin
      op(1, 1, 15'h00C0 + 15'(i), 8'h11 * 8'(i), i[1], i[0]);
      chk("io addr", 15'(8'hC0 + i), i_cmbi_mem.last_addr[7:0]);
      chk("io data", 15'(8'h11 * i), i_cmbi_mem.last_wdata);
    end
    $display("t_io done");
  endtask

  task automatic t_enable();
    {address_drive_enable_b_i, data_drive_enable_b_i, drv_seen} = 3'h7;
    repeat (3) @(negedge ref_clk_i);
    drv_seen = 1'b0;
    chk("addr float", 1, low_address_lines_oe_b_o);
    op(0, 1, 15'h0010, 8'h96, 0, 0);
    chk("data float", 0, drv_seen);
    {address_drive_enable_b_i, data_drive_enable_b_i} = 2'h0;
    repeat (3) @(negedge ref_clk_i);
    chk("addr drive", 0, low_address_lines_oe_b_o);
    $display("t_enable done");
  endtask

  task automatic t_flag_sense();
    set_status(8'h40);
    chk("flag on", 1, flag_o);
    sense_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk("sense", 8'hC0, core_status_o);
    sense_i = 1'b0;
    set_status(8'h00);
    chk("flag off", 0, flag_o);
    $display("t_flag_sense done");
  endtask

  task automatic t_pause();
    pause_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    chk("run mid instr", 1, run_wait_o);
    pulse(core_instr_end_i);
    repeat (6) @(negedge ref_clk_i);
    chk("waiting", 0, run_wait_o);
    pause_i = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    chk("running", 1, run_wait_o);
    $display("t_pause done");
  endtask

  task automatic t_int();
    int n;
    n = 0;
    {delay, rd_val, ack_seen, interrupt_request_i} = {4'h2, 8'h77, 2'h1};
    pulse(core_instr_end_i);
    while (core_int_enter_o !== 1'b1 && n < 80) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("int enter", 1, core_int_enter_o);
    chk("int ack", 1, ack_seen);
    chk("vector", 8'h77, core_int_vector_o);
    chk("vec addr", 0, i_cmbi_mem.last_addr);
    chk("inhibit", 1, core_status_o[5]);
    // Acknowledge stays up until the synced acknowledge drops, so let the fetch end first.
    repeat (6) @(negedge ref_clk_i);
    ack_seen = 1'b0;
    pulse(core_instr_end_i);
    repeat (20) @(negedge ref_clk_i);
    chk("inhibited", 0, ack_seen);
    interrupt_request_i = 1'b0;
    set_status(8'h00);
    $display("t_int done");
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {rst_b_i, core_req_valid_i, core_req_is_io_i, core_req_write_i, core_req_addr_i} = '0;
    {core_req_wdata_i, core_req_io_ext_i, core_req_io_data_i, core_instr_end_i} = '0;
    {core_status_wr_i, core_status_wdata_i, address_drive_enable_b_i, data_drive_enable_b_i} = '0;
    {sense_i, interrupt_request_i, pause_i, delay, rd_val, drv_seen, ack_seen} = '0;
    repeat (5) @(negedge ref_clk_i);
    t_reset();
    @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    t_mem();
    t_io();
    t_enable();
    t_flag_sense();
    t_pause();
    t_int();
    close_out();
  end
endmodule
